/* hw/spu_defs.vh */
// Constants of the serial port unit: register indices, field positions, reset values.
// Assumes the includer works on 8-bit registers in the low byte of a 32-bit bus word.
`ifndef SPU_DEFS_VH
`define SPU_DEFS_VH

// Printed register offsets are kept as indices; bus word address = low bits of index
`define SPU_FRAME_IDX 32'h05fffec0
`define SPU_BAUD_IDX 32'h05fffec1
`define SPU_CTRL_IDX 32'h05fffec2
`define SPU_TXDATA_IDX 32'h05fffec3
`define SPU_STAT_IDX 32'h05fffec4
`define SPU_RXDATA_IDX 32'h05fffec5
`define SPU_IRQ_STAT_IDX 32'h05fffec6
`define SPU_IRQ_MASK_IDX 32'h05fffec7

`define SPU_FRAME_RST 8'h00
`define SPU_BAUD_RST 8'hff
`define SPU_CTRL_RST 8'h00
`define SPU_STAT_RST 8'h84

// Frame format fields
`define SPU_F_SYNC 7
`define SPU_F_CHR7 6
`define SPU_F_PAR_ON 5
`define SPU_F_ODD 4
`define SPU_F_STOP2 3
`define SPU_F_MP 2
// Control fields
`define SPU_C_TIE 7
`define SPU_C_RIE 6
`define SPU_C_TE 5
`define SPU_C_RE 4
`define SPU_C_ADDR_WAIT_IRQ_EN 3
`define SPU_C_TX_DONE_IRQ_EN 2
`define SPU_C_CLK_SRC_SEL_HI 1
`define SPU_C_CLK_SRC_SEL_LO 0
// Status fields
`define SPU_S_TDRE 7
`define SPU_S_RX_FULL_FLAG 6
`define SPU_S_OVERRUN_FLAG 5
`define SPU_S_FER 4
`define SPU_S_PER 3
`define SPU_S_TEND 2
`define SPU_S_MPB 1
`define SPU_S_MPBT 0

// Prescaler terminal counts for /1, /4, /16, /64
`define SPU_PRE_DIV1 6'h00
`define SPU_PRE_DIV4 6'h03
`define SPU_PRE_DIV16 6'h0f
`define SPU_PRE_DIV64 6'h3f
// Asynchronous bit = 16 rate ticks; start bit checked at its middle
`define SPU_OVS_LAST 4'hf
`define SPU_OVS_MID 4'h7

`endif

/* hw/spu_rate_gen.v */
// Bit-rate tick generator: prescaler followed by the divisor counter.
// Assumes a single clock; the tick is a one-cycle enable pulse.
`timescale 1ns/1ns
`include "spu_defs.vh"
module spu_rate_gen
(
  input wire clock_in,
  input wire nrst_in,
  input wire [1:0] prescale_sel_in,
  input wire [7:0] divisor_in,
  output reg tick_out
);

  reg [5:0] pre_r;
  reg [7:0] div_r;
  reg [5:0] pre_last;
  wire pre_tick;

  // ----------------------------------------
  // Prescaler select
  // ----------------------------------------
  always @*
  begin
    case (prescale_sel_in)
      2'b00: pre_last = `SPU_PRE_DIV1;
      2'b01: pre_last = `SPU_PRE_DIV4;
      2'b10: pre_last = `SPU_PRE_DIV16;
      default: pre_last = `SPU_PRE_DIV64;
    endcase
  end

  assign pre_tick = (pre_r >= pre_last);

  // Tick every (divisor + 1) prescaled clocks
  always @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      pre_r <= 6'h00;
      div_r <= 8'h00;
      tick_out <= 1'b0;
    end
    else
    begin
      tick_out <= 1'b0;
      pre_r <= pre_tick ? 6'h00 : pre_r + 6'h01;
      if (pre_tick)
      begin
        if (div_r >= divisor_in)
        begin
          div_r <= 8'h00;
          tick_out <= 1'b1;
        end
        else
          div_r <= div_r + 8'h01;
      end
    end
  end

endmodule

/* hw/spu_serial_port_unit.v */
// Serial port unit: frame format, bit rate and control registers plus the
// transmit and receive engines they steer, on an Avalon-MM slave.
// Assumes rxd_in and sck_in are already synchronous to clock_in.
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ns
`include "spu_defs.vh"
module spu_serial_port_unit
(
  input wire clock_in,
  input wire nrst_in,
  input wire [3:0] address_in,
  input wire read_in,
  input wire write_in,
  input wire [31:0] writedata_in,
  output reg [31:0] readdata_out,
  output wire waitrequest_out,
  input wire rxd_in,
  output reg txd_out,
  input wire sck_in,
  output reg sck_out,
  output wire sck_oe_out,
  output wire tx_empty_irq_out,
  output wire rx_full_irq_out,
  output wire rx_error_irq_out,
  output wire tx_done_irq_out,
  output wire irq_out
);

  localparam TX_IDLE = 1'b0;
  localparam TX_SHIFT = 1'b1;
  localparam RX_IDLE = 2'b00;
  localparam RX_START = 2'b01;
  localparam RX_DATA = 2'b10;

  reg [7:0] frame_format_reg;
  reg [7:0] baud_divisor_reg;
  reg [7:0] serial_ctrl_reg;
  reg [7:0] tdr_r;
  reg [7:0] stat_r;
  reg [7:0] rdr_r;
  reg [3:0] ist_r;
  reg [3:0] imask_r;
  reg [3:0] req_d_r;
  reg ack_r;
  reg tx_st_r;
  reg [11:0] tx_sh_r;
  reg [3:0] tx_cnt_r;
  reg [3:0] tx_ovs_r;
  reg [1:0] rx_st_r;
  reg [11:0] rx_sh_r;
  reg [3:0] rx_cnt_r;
  reg [3:0] rx_ovs_r;
  reg sck_in_d_r;
  reg [11:0] frame_nxt;
  reg [3:0] flen_nxt;
  integer k;
  integer i;

  wire tick;
  wire acc = ack_r & (read_in | write_in);
  wire wr = acc & write_in;
  wire [31:0] word_addr = {28'h0000000, address_in};
  wire is_sync = frame_format_reg[`SPU_F_SYNC];
  wire chr7 = frame_format_reg[`SPU_F_CHR7];
  wire par_on = frame_format_reg[`SPU_F_PAR_ON];
  wire odd = frame_format_reg[`SPU_F_ODD];
  wire stop2 = frame_format_reg[`SPU_F_STOP2];
  wire mp_on = frame_format_reg[`SPU_F_MP];
  wire te = serial_ctrl_reg[`SPU_C_TE];
  wire re = serial_ctrl_reg[`SPU_C_RE];
  wire ext_clk = serial_ctrl_reg[`SPU_C_CLK_SRC_SEL_HI];
  wire async_mode = ~is_sync;
  // Sync mode forces 8 data bits and no parity, address bit or stop bits
  wire [3:0] nd = (async_mode & chr7) ? 4'd7 : 4'd8;
  wire use_par = async_mode & par_on;
  wire use_mp = async_mode & mp_on;
  wire sck_run = tx_st_r | re;
  wire ext_rise = sck_in & ~sck_in_d_r;
  wire ext_fall = ~sck_in & sck_in_d_r;
  wire int_rise = tick & sck_run & ~sck_out;
  wire int_fall = tick & sck_run & sck_out;
  wire s_rise = ext_clk ? ext_rise : int_rise;
  wire s_fall = ext_clk ? ext_fall : int_fall;
  // Bits before the stop bit; the stop sample itself ends the frame
  wire [3:0] rx_len = nd + {3'b000, use_par} + {3'b000, use_mp};
  wire [7:0] rx_data = chr7 & async_mode ? {1'b0, rx_sh_r[7:1]} : rx_sh_r[8:1];
  wire rx_bit_par = rx_sh_r[nd + 4'd1];
  wire rx_bit_mp = rx_sh_r[nd + 4'd1 + {3'b000, use_par}];
  wire rx_par_calc = ^rx_data ^ odd;
  wire rx_done_async = (rx_st_r == RX_DATA) & tick & (rx_ovs_r == `SPU_OVS_LAST)
                       & (rx_cnt_r == rx_len) & async_mode;
  wire rx_done_sync = (rx_st_r == RX_DATA) & is_sync & s_rise & (rx_cnt_r == 4'd7);
  wire [3:0] req = {tx_done_irq_out, rx_error_irq_out, rx_full_irq_out, tx_empty_irq_out};

  spu_rate_gen u_rate
  (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .prescale_sel_in(frame_format_reg[1:0]),
    .divisor_in(baud_divisor_reg),
    .tick_out(tick)
  );

  // ----------------------------------------
  // Bus slave: one wait state on every access
  // ----------------------------------------
  assign waitrequest_out = (read_in | write_in) & ~ack_r;

  // ----------------------------------------
  // Interrupt requests
  // ----------------------------------------
  assign tx_empty_irq_out = serial_ctrl_reg[`SPU_C_TIE] & stat_r[`SPU_S_TDRE];
  assign rx_full_irq_out = serial_ctrl_reg[`SPU_C_RIE] & stat_r[`SPU_S_RX_FULL_FLAG];
  assign rx_error_irq_out = serial_ctrl_reg[`SPU_C_RIE]
                            & (stat_r[`SPU_S_OVERRUN_FLAG] | stat_r[`SPU_S_FER] | stat_r[`SPU_S_PER]);
  assign tx_done_irq_out = serial_ctrl_reg[`SPU_C_TX_DONE_IRQ_EN] & stat_r[`SPU_S_TEND];
  assign irq_out = |(ist_r & imask_r);
  // Pin drives only with internal clock: in sync mode, or when clock output is asked for
  assign sck_oe_out = ~ext_clk & (is_sync | serial_ctrl_reg[`SPU_C_CLK_SRC_SEL_LO]);

  // ----------------------------------------
  // Transmit frame assembly, LSB first
  // ----------------------------------------
  always @*
  begin
    frame_nxt = 12'hfff;
    frame_nxt[0] = 1'b0;
    k = 1;
    for (i = 0; i < 8; i = i + 1)
    begin
      if (i < nd)
      begin
        frame_nxt[k] = tdr_r[i];
        k = k + 1;
      end
    end
    if (use_par)
    begin
      frame_nxt[k] = ^(tdr_r & (chr7 ? 8'h7f : 8'hff)) ^ odd;
      k = k + 1;
    end
    if (use_mp)
    begin
      frame_nxt[k] = stat_r[`SPU_S_MPBT];
      k = k + 1;
    end
    flen_nxt = k[3:0] + (stop2 ? 4'd2 : 4'd1);
    if (is_sync)
    begin
      frame_nxt = {4'hf, tdr_r};
      flen_nxt = 4'd8;
    end
  end

  // ----------------------------------------
  // Registers, flags and engines
  // ----------------------------------------
  always @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      frame_format_reg <= `SPU_FRAME_RST;
      baud_divisor_reg <= `SPU_BAUD_RST;
      serial_ctrl_reg <= `SPU_CTRL_RST;
      tdr_r <= 8'hff;
      stat_r <= `SPU_STAT_RST;
      rdr_r <= 8'h00;
      ist_r <= 4'h0;
      imask_r <= 4'h0;
      req_d_r <= 4'h0;
      ack_r <= 1'b0;
      readdata_out <= 32'h00000000;
      tx_st_r <= TX_IDLE;
      tx_sh_r <= 12'hfff;
      tx_cnt_r <= 4'h0;
      tx_ovs_r <= 4'h0;
      txd_out <= 1'b1;
      rx_st_r <= RX_IDLE;
      rx_sh_r <= 12'h000;
      rx_cnt_r <= 4'h0;
      rx_ovs_r <= 4'h0;
      sck_in_d_r <= 1'b1;
      sck_out <= 1'b1;
    end
    else
    begin
      ack_r <= (read_in | write_in) & ~ack_r;
      sck_in_d_r <= sck_in;
      req_d_r <= req;
      if (int_rise | int_fall)
        sck_out <= ~sck_out;
      else if (!sck_run)
        sck_out <= 1'b1;

      // Register reads load in the wait cycle, so data stand when waitrequest drops
      if (read_in && !ack_r)
      begin
        case (word_addr)
          `SPU_FRAME_IDX & 32'hf: readdata_out <= {24'h000000, frame_format_reg};
          `SPU_BAUD_IDX & 32'hf: readdata_out <= {24'h000000, baud_divisor_reg};
          `SPU_CTRL_IDX & 32'hf: readdata_out <= {24'h000000, serial_ctrl_reg};
          `SPU_TXDATA_IDX & 32'hf: readdata_out <= {24'h000000, tdr_r};
          `SPU_STAT_IDX & 32'hf: readdata_out <= {24'h000000, stat_r};
          `SPU_RXDATA_IDX & 32'hf: readdata_out <= {24'h000000, rdr_r};
          `SPU_IRQ_STAT_IDX & 32'hf: readdata_out <= {28'h0000000, ist_r};
          `SPU_IRQ_MASK_IDX & 32'hf: readdata_out <= {28'h0000000, imask_r};
          default: readdata_out <= 32'h00000000;
        endcase
      end

      // Register writes; hardware sets below override software clears
      if (wr)
      begin
        case (word_addr)
          `SPU_FRAME_IDX & 32'hf: frame_format_reg <= writedata_in[7:0];
          `SPU_BAUD_IDX & 32'hf: baud_divisor_reg <= writedata_in[7:0];
          `SPU_CTRL_IDX & 32'hf: serial_ctrl_reg <= writedata_in[7:0];
          `SPU_TXDATA_IDX & 32'hf:
          begin
            tdr_r <= writedata_in[7:0];
            stat_r[`SPU_S_TDRE] <= 1'b0;
            stat_r[`SPU_S_TEND] <= 1'b0;
          end
          // Flags in bits 7:3 clear by writing 0; address-bit-to-send is plain read/write
          `SPU_STAT_IDX & 32'hf:
          begin
            stat_r[7:3] <= stat_r[7:3] & writedata_in[7:3];
            stat_r[`SPU_S_MPBT] <= writedata_in[`SPU_S_MPBT];
          end
          `SPU_IRQ_STAT_IDX & 32'hf: ist_r <= ist_r & ~writedata_in[3:0];
          `SPU_IRQ_MASK_IDX & 32'hf: imask_r <= writedata_in[3:0];
          default: ;
        endcase
      end
      // Sticky events on each request rising
      ist_r[0] <= (wr && word_addr == (`SPU_IRQ_STAT_IDX & 32'hf) && writedata_in[0]
                   ? 1'b0 : ist_r[0]) | (req[0] & ~req_d_r[0]);
      ist_r[1] <= (wr && word_addr == (`SPU_IRQ_STAT_IDX & 32'hf) && writedata_in[1]
                   ? 1'b0 : ist_r[1]) | (req[1] & ~req_d_r[1]);
      ist_r[2] <= (wr && word_addr == (`SPU_IRQ_STAT_IDX & 32'hf) && writedata_in[2]
                   ? 1'b0 : ist_r[2]) | (req[2] & ~req_d_r[2]);
      ist_r[3] <= (wr && word_addr == (`SPU_IRQ_STAT_IDX & 32'hf) && writedata_in[3]
                   ? 1'b0 : ist_r[3]) | (req[3] & ~req_d_r[3]);

      // Transmitter
      if (!te)
      begin
        tx_st_r <= TX_IDLE;
        txd_out <= 1'b1;
        stat_r[`SPU_S_TDRE] <= 1'b1;
        stat_r[`SPU_S_TEND] <= 1'b1;
      end
      else
      begin
        case (tx_st_r)
          TX_IDLE:
          begin
            // Async frames start on a rate tick so the start bit lasts sixteen full ticks
            if (!stat_r[`SPU_S_TDRE] && !(wr && word_addr == (`SPU_TXDATA_IDX & 32'hf))
                && (is_sync || tick))
            begin
              tx_sh_r <= frame_nxt;
              tx_cnt_r <= flen_nxt;
              tx_ovs_r <= 4'h0;
              tx_st_r <= TX_SHIFT;
              stat_r[`SPU_S_TDRE] <= 1'b1;
              stat_r[`SPU_S_TEND] <= 1'b0;
              if (async_mode)
                txd_out <= frame_nxt[0];
            end
          end
          TX_SHIFT:
          begin
            if (is_sync ? s_fall : (tick && tx_ovs_r == `SPU_OVS_LAST))
            begin
              tx_cnt_r <= tx_cnt_r - 4'd1;
              if (is_sync)
                txd_out <= tx_sh_r[0];
              else
                txd_out <= tx_sh_r[1];
              tx_sh_r <= {1'b1, tx_sh_r[11:1]};
              if (tx_cnt_r == 4'd1)
              begin
                tx_st_r <= TX_IDLE;
                txd_out <= is_sync ? tx_sh_r[0] : 1'b1;
                stat_r[`SPU_S_TEND] <= stat_r[`SPU_S_TDRE];
              end
            end
            if (tick)
              tx_ovs_r <= tx_ovs_r + 4'h1;
          end
          default: tx_st_r <= TX_IDLE;
        endcase
      end

      // Receiver
      if (!re)
        rx_st_r <= RX_IDLE;
      else
      begin
        case (rx_st_r)
          RX_IDLE:
          begin
            rx_cnt_r <= 4'h0;
            rx_ovs_r <= 4'h0;
            if (is_sync)
              rx_st_r <= RX_DATA;
            else if (!rxd_in)
              rx_st_r <= RX_START;
          end
          RX_START:
          begin
            if (tick)
            begin
              rx_ovs_r <= rx_ovs_r + 4'h1;
              if (rx_ovs_r == `SPU_OVS_MID)
              begin
                rx_ovs_r <= 4'h0;
                rx_st_r <= rxd_in ? RX_IDLE : RX_DATA;
              end
            end
          end
          RX_DATA:
          begin
            if (is_sync ? s_rise : (tick && rx_ovs_r == `SPU_OVS_LAST))
            begin
              rx_cnt_r <= rx_cnt_r + 4'h1;
              rx_sh_r[rx_cnt_r + 4'd1] <= rxd_in;
            end
            if (tick)
              rx_ovs_r <= rx_ovs_r + 4'h1;
            if (rx_done_sync)
            begin
              rx_st_r <= RX_IDLE;
              if (stat_r[`SPU_S_RX_FULL_FLAG])
                stat_r[`SPU_S_OVERRUN_FLAG] <= 1'b1;
              else
              begin
                rdr_r <= {rxd_in, rx_sh_r[7:1]};
                stat_r[`SPU_S_RX_FULL_FLAG] <= 1'b1;
              end
            end
            else if (rx_done_async)
            begin
              rx_st_r <= RX_IDLE;
              // Stop bit is rxd_in now; only the first stop bit is checked
              if (use_mp)
                stat_r[`SPU_S_MPB] <= rx_bit_mp;
              if (use_mp && rx_bit_mp)
                serial_ctrl_reg[`SPU_C_ADDR_WAIT_IRQ_EN] <= 1'b0;
              if (serial_ctrl_reg[`SPU_C_ADDR_WAIT_IRQ_EN] && !(use_mp && rx_bit_mp))
                ; // Non-address character while waiting: no flags, data dropped
              else if (stat_r[`SPU_S_RX_FULL_FLAG])
                stat_r[`SPU_S_OVERRUN_FLAG] <= 1'b1;
              else if (!rxd_in)
              begin
                stat_r[`SPU_S_FER] <= 1'b1;
                rdr_r <= rx_data;
              end
              else if (use_par && (rx_bit_par != rx_par_calc))
              begin
                stat_r[`SPU_S_PER] <= 1'b1;
                rdr_r <= rx_data;
              end
              else
              begin
                rdr_r <= rx_data;
                stat_r[`SPU_S_RX_FULL_FLAG] <= 1'b1;
              end
            end
          end
          default: rx_st_r <= RX_IDLE;
        endcase
      end
    end
  end

endmodule

/* test/spu_remote_station.sv */
// Remote serial station on the far side of the port: start/stop frames.
// Assumes the caller gives the frame format byte and the bit length in clocks.
`timescale 1ns/1ns
module spu_remote_station
(
  input wire clock_in,
  input wire txd_in,
  output reg rxd_out
);
  // Released line sits at mark, as a pulled-up receive pin would
  initial rxd_out = 1'b1;

  task automatic send(input [7:0] d, input [7:0] fmt, input addr_flag_bit, input bad, input int bclk);
    reg [7:0] dm;
    bit q[$];
    int i;
  begin
    dm = fmt[6] ? {1'b0, d[6:0]} : d;
    q.push_back(1'b0);
    for (i = 0; i < (fmt[6] ? 7 : 8); i++)
      q.push_back(dm[i]);
    if (fmt[5])
      q.push_back(^dm ^ fmt[4] ^ bad);
    if (fmt[2])
      q.push_back(addr_flag_bit);
    q.push_back(1'b1);
    if (fmt[3])
      q.push_back(1'b1);
    foreach (q[j])
    begin
      rxd_out <= q[j];
      repeat (bclk) @(posedge clock_in);
    end
  end
  endtask

  task automatic take(input int bclk, output b);
  begin
    repeat (bclk) @(posedge clock_in);
    b = txd_in;
  end
  endtask

  // Result is {start low and stop bits high, address bit, parity bit, data}
  task automatic recv(input [7:0] fmt, input int bclk, output [10:0] w);
    reg [7:0] d;
    reg p, m, s, ok;
    int i;
  begin
    d = 8'h00;
    p = 1'b0;
    m = 1'b0;
    i = 0;
    while (txd_in !== 1'b0 && i < 5000)
    begin
      @(posedge clock_in);
      i++;
    end
    repeat (bclk / 2) @(posedge clock_in);
    ok = (txd_in === 1'b0);
    for (i = 0; i < (fmt[6] ? 7 : 8); i++)
    begin
      take(bclk, s);
      d[i] = s;
    end
    if (fmt[5])
      take(bclk, p);
    if (fmt[2])
      take(bclk, m);
    take(bclk, s);
    ok = ok & (s === 1'b1);
    if (fmt[3])
    begin
      take(bclk, s);
      ok = ok & (s === 1'b1);
    end
    w = {ok, m, p, d};
  end
  endtask
endmodule

/* test/spu_serial_port_unit_monitor.sv */
// Checker for the serial port unit, bound to the top module ports.
// Assumes one clock; a register write lands at the edge where waitrequest is low.
`timescale 1ns/1ns
module spu_serial_port_unit_monitor
(
  input wire clock_in,
  input wire nrst_in,
  input wire [3:0] address_in,
  input wire read_in,
  input wire write_in,
  input wire [31:0] writedata_in,
  input wire [31:0] readdata_out,
  input wire waitrequest_out,
  input wire rxd_in,
  input wire txd_out,
  input wire sck_in,
  input wire sck_out,
  input wire sck_oe_out,
  input wire tx_empty_irq_out,
  input wire rx_full_irq_out,
  input wire rx_error_irq_out,
  input wire tx_done_irq_out,
  input wire irq_out
);
  reg [7:0] frm_sh_r;
  reg [7:0] baud_sh_r;
  reg [7:0] ctrl_sh_r;
  wire wr_take = write_in && !waitrequest_out;

  // ----------------------------------------
  // Shadows of the software-written registers
  // ----------------------------------------
  // Only fields that hardware never changes by itself are used; control bit 3 is not
  always @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      frm_sh_r <= 8'h00;
      baud_sh_r <= 8'hff;
      ctrl_sh_r <= 8'h00;
    end
    else if (wr_take)
    begin
      if (address_in == 4'h0)
        frm_sh_r <= writedata_in[7:0];
      if (address_in == 4'h1)
        baud_sh_r <= writedata_in[7:0];
      if (address_in == 4'h2)
        ctrl_sh_r <= writedata_in[7:0];
    end
  end

  default clocking mon_cb @(posedge clock_in);
  endclocking
  default disable iff (!nrst_in);

  AST_ONE_WAIT: assert property ($rose(read_in || write_in) |-> waitrequest_out ##1 !waitrequest_out)
    else $error("bus answer not after one wait state");
  AST_BAUD_RD: assert property (read_in && !waitrequest_out && address_in == 4'h1 |-> readdata_out == {24'h0, baud_sh_r})
    else $error("divisor read-back differs from last write");
  AST_TXE_GATE: assert property (!ctrl_sh_r[7] |-> !tx_empty_irq_out)
    else $error("transmit-empty request while disabled");
  AST_RX_GATE: assert property (!ctrl_sh_r[6] |-> !rx_full_irq_out && !rx_error_irq_out)
    else $error("receive request while disabled");
  AST_TDN_GATE: assert property (!ctrl_sh_r[2] |-> !tx_done_irq_out)
    else $error("transmit-done request while disabled");
  AST_TX_IDLE: assert property (!ctrl_sh_r[5] |-> txd_out)
    else $error("transmit line active with transmitter off");
  AST_SCK_OE: assert property (sck_oe_out == (!ctrl_sh_r[1] && (frm_sh_r[7] || ctrl_sh_r[0])))
    else $error("serial clock pin direction wrong");
  AST_START16: assert property (!frm_sh_r[7] && $fell(txd_out) |-> (!txd_out)[*8] ##1 (!txd_out)[*8])
    else $error("low bit shorter than sixteen clocks");
endmodule

/* test/spu_serial_port_unit_tb_top.sv */
// Testbench: register table, frames both ways, prescaler timing, interrupt block.
// Assumes the design, its monitor and the remote station are compiled first.
`timescale 1ns/1ns
module spu_serial_port_unit_tb_top;
  reg clock_in, nrst_in, read_in, write_in, sck_in;
  reg [3:0] address_in;
  reg [31:0] writedata_in;
  wire [31:0] readdata_out;
  wire waitrequest_out, rxd_in, txd_out, sck_out, sck_oe_out, irq_out;
  wire tx_empty_irq_out, rx_full_irq_out, rx_error_irq_out, tx_done_irq_out;
  int num_errors, compares, i, n, t;
  reg [7:0] q, fmt, d, st;
  reg [10:0] w;
  // Address, write, data, read-back, {sck_oe, tx_empty, rx_full, rx_error, tx_done}
  reg [25:0] reg_rows [0:14];
  // Frame, control, data, {address bit, bad parity}, status, control read-back
  reg [41:0] rx_rows [0:4];

  spu_serial_port_unit u_dut (.clock_in(clock_in), .nrst_in(nrst_in),
    .address_in(address_in), .read_in(read_in), .write_in(write_in),
    .writedata_in(writedata_in), .readdata_out(readdata_out),
    .waitrequest_out(waitrequest_out), .rxd_in(rxd_in), .txd_out(txd_out),
    .sck_in(sck_in), .sck_out(sck_out), .sck_oe_out(sck_oe_out),
    .tx_empty_irq_out(tx_empty_irq_out), .rx_full_irq_out(rx_full_irq_out),
    .rx_error_irq_out(rx_error_irq_out), .tx_done_irq_out(tx_done_irq_out),
    .irq_out(irq_out));
  spu_remote_station u_peer (.clock_in(clock_in), .txd_in(txd_out), .rxd_out(rxd_in));

  initial
  begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end

  task chk(input [31:0] got, input [31:0] exp);
  begin
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask

  task bus(input bit wr, input [3:0] a, input [7:0] dat, output [7:0] rd);
    int k;
  begin
    k = 0;
    @(posedge clock_in);
    read_in <= !wr;
    write_in <= wr;
    address_in <= a;
    writedata_in <= {24'h0, dat};
    @(posedge clock_in);
    while (waitrequest_out !== 1'b0 && k < 32)
    begin
      @(posedge clock_in);
      k++;
    end
    if (k == 32)
      num_errors++;
    rd = readdata_out[7:0];
    read_in <= 1'b0;
    write_in <= 1'b0;
  end
  endtask

  task wrap_up;
  begin
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask

  // Cycle budget: about 29000 cycles of tests, nearly twice that as margin
  initial
  begin
    repeat (80000) @(posedge clock_in);
    num_errors++;
    wrap_up;
  end

  initial
  begin
    num_errors = 0;
    compares = 0;
    {nrst_in, read_in, write_in, address_in, writedata_in} = '0;
    sck_in = 1'b1;
    reg_rows = '{{4'h0,1'b0,8'h00,8'h00,5'h00}, {4'h1,1'b0,8'h00,8'hff,5'h00},
      {4'h2,1'b0,8'h00,8'h00,5'h00}, {4'h4,1'b0,8'h00,8'h84,5'h00},
      {4'h8,1'b0,8'h00,8'h00,5'h00}, {4'h8,1'b1,8'h5a,8'h00,5'h00},
      {4'h1,1'b1,8'h3c,8'h3c,5'h00}, {4'h0,1'b1,8'h7f,8'h7f,5'h00},
      {4'h0,1'b1,8'h80,8'h80,5'h10}, {4'h0,1'b1,8'h00,8'h00,5'h00},
      {4'h2,1'b1,8'h01,8'h01,5'h10}, {4'h2,1'b1,8'h02,8'h02,5'h00},
      {4'h2,1'b1,8'h80,8'h80,5'h08}, {4'h2,1'b1,8'h04,8'h04,5'h01},
      {4'h2,1'b1,8'h40,8'h40,5'h00}};
    rx_rows = '{{8'h00,8'h40,8'ha5,2'b00,8'h84,8'h40}, {8'h00,8'h50,8'h3c,2'b00,8'hc4,8'h50},
      {8'h30,8'h50,8'h5a,2'b01,8'h8c,8'h50}, {8'h04,8'h58,8'h11,2'b00,8'h84,8'h58},
      {8'h04,8'h58,8'h22,2'b10,8'hc6,8'h50}};
    repeat (16) @(posedge clock_in);
    nrst_in <= 1'b1;
    for (i = 0; i < 15; i++)
    begin
      if (reg_rows[i][21])
        bus(1'b1, reg_rows[i][25:22], reg_rows[i][20:13], q);
      bus(1'b0, reg_rows[i][25:22], 8'h00, q);
      chk(q, reg_rows[i][12:5]);
      chk({sck_oe_out, tx_empty_irq_out, rx_full_irq_out, rx_error_irq_out, tx_done_irq_out},
        reg_rows[i][4:0]);
    end
    // Transmit: 8N1, 7-bit even, 8-bit odd two stops, parity with address bit
    bus(1'b1, 4'h1, 8'h00, q);
    for (i = 0; i < 4; i++)
    begin
      fmt = 32'h24386000 >> (8 * i);
      d = 32'h5b963ca5 >> (8 * i);
      bus(1'b1, 4'h0, fmt, q);
      bus(1'b1, 4'h2, 8'h20, q);
      bus(1'b1, 4'h4, 8'hf9, q);
      fork
        bus(1'b1, 4'h3, d, q);
        u_peer.recv(fmt, 16, w);
      join
      d = fmt[6] ? {1'b0, d[6:0]} : d;
      chk(w, {1'b1, fmt[2], fmt[5] & (^d ^ fmt[4]), d});
    end
    // Receive: receiver off, normal, parity error, address wait skip and wake
    for (i = 0; i < 5; i++)
    begin
      bus(1'b1, 4'h0, rx_rows[i][41:34], q);
      bus(1'b1, 4'h2, rx_rows[i][33:26], q);
      bus(1'b1, 4'h4, 8'h06, q);
      u_peer.send(rx_rows[i][25:18], rx_rows[i][41:34], rx_rows[i][17], rx_rows[i][16], 16);
      repeat (16) @(posedge clock_in);
      st = rx_rows[i][15:8];
      bus(1'b0, 4'h4, 8'h00, q);
      chk(q, st);
      bus(1'b0, 4'h2, 8'h00, q);
      chk(q, rx_rows[i][7:0]);
      chk({rx_full_irq_out, rx_error_irq_out}, {st[6], |st[5:3]});
      bus(1'b0, 4'h5, 8'h00, q);
      if (st[6])
        chk(q, rx_rows[i][25:18]);
    end
    // Low run of a zero byte is nine bits of 16 rate ticks each
    bus(1'b1, 4'h1, 8'h01, q);
    bus(1'b1, 4'h2, 8'h20, q);
    for (i = 0; i < 4; i++)
    begin
      bus(1'b1, 4'h0, i[7:0], q);
      n = 0;
      t = 0;
      fork
        bus(1'b1, 4'h3, 8'h00, q);
        begin
          while (txd_out !== 1'b0 && t < 20000)
          begin
            @(posedge clock_in);
            t++;
          end
          while (txd_out === 1'b0 && n < 30000)
          begin
            @(posedge clock_in);
            n++;
          end
        end
      join
      chk(n, 32'd288 << (2 * i));
    end
    bus(1'b1, 4'h2, 8'h00, q);
    // Clocked mode: eight bits LSB first, taken at each rising serial clock
    bus(1'b1, 4'h0, 8'h80, q);
    bus(1'b1, 4'h2, 8'h20, q);
    fork
      bus(1'b1, 4'h3, 8'hc5, q);
      for (n = 0; n < 8; n++)
      begin
        @(posedge sck_out);
        d[n] = txd_out;
      end
    join
    chk(d, 8'hc5);
    bus(1'b1, 4'h7, 8'h00, q);
    bus(1'b1, 4'h6, 8'h0f, q);
    bus(1'b1, 4'h2, 8'h84, q);
    bus(1'b0, 4'h6, 8'h00, q);
    chk(q, 8'h09);
    chk(irq_out, 1'b0);
    bus(1'b1, 4'h7, 8'h01, q);
    bus(1'b0, 4'h7, 8'h00, q);
    chk(irq_out, 1'b1);
    bus(1'b1, 4'h6, 8'h01, q);
    bus(1'b0, 4'h6, 8'h00, q);
    chk(q, 8'h08);
    chk(irq_out, 1'b0);
    // Reset in mid-run returns divisor, control and interrupt state to defaults
    nrst_in <= 1'b0;
    repeat (4) @(posedge clock_in);
    nrst_in <= 1'b1;
    bus(1'b0, 4'h1, 8'h00, q);
    chk(q, 8'hff);
    bus(1'b0, 4'h2, 8'h00, q);
    chk(q, 8'h00);
    chk(irq_out, 1'b0);
    wrap_up;
  end
endmodule

bind spu_serial_port_unit spu_serial_port_unit_monitor u_mon (.clock_in(clock_in),
  .nrst_in(nrst_in), .address_in(address_in), .read_in(read_in), .write_in(write_in),
  .writedata_in(writedata_in), .readdata_out(readdata_out),
  .waitrequest_out(waitrequest_out), .rxd_in(rxd_in), .txd_out(txd_out), .sck_in(sck_in),
  .sck_out(sck_out), .sck_oe_out(sck_oe_out), .tx_empty_irq_out(tx_empty_irq_out),
  .rx_full_irq_out(rx_full_irq_out), .rx_error_irq_out(rx_error_irq_out),
  .tx_done_irq_out(tx_done_irq_out), .irq_out(irq_out));
